// ==== shared/dtov_defines.vh ====
`ifndef DTOV_DEFINES_VH
`define DTOV_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define DTOV_ADDR_CTRL 8'h00
`define DTOV_ADDR_LEVEL 8'h04
`define DTOV_ADDR_DELAY 8'h08
`define DTOV_ADDR_NOMINAL 8'h0C
`define DTOV_ADDR_STATUS 8'h10
`define DTOV_ADDR_IRQ_STAT 8'h14
`define DTOV_ADDR_IRQ_MASK 8'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define DTOV_CTRL_ENABLE_BIT 0
`define DTOV_CTRL_START_ONLY_BIT 1
`define DTOV_CTRL_P2P_BIT 2

// ----------------------------------------------------------------------------
// Setting ranges and reset values
// ----------------------------------------------------------------------------
`define DTOV_LEVEL_MIN 8'h1E
`define DTOV_LEVEL_MAX 8'h82
`define DTOV_LEVEL_RESET 8'h6E
`define DTOV_HYST_MIN 4'h1
`define DTOV_HYST_MAX 4'hA
`define DTOV_HYST_RESET 4'h5
`define DTOV_DELAY_MAX 16'hEA60
`define DTOV_DELAY_RESET 16'h0064
`define DTOV_NOMINAL_RESET 16'h2710

// ----------------------------------------------------------------------------
// Timing: one millisecond in clock cycles at 40 MHz
// ----------------------------------------------------------------------------
`define DTOV_CLK_HZ 40000000
`define DTOV_MS_PER_S 1000
`define DTOV_CYCLES_PER_MS (`DTOV_CLK_HZ / `DTOV_MS_PER_S)

// ----------------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------------
`define DTOV_IRQ_START_BIT 0
`define DTOV_IRQ_TRIP_BIT 1

`endif

// ==== verilog/dtov_trip.v ====
// Summary of operation
// [RQ1] Operation selector off/on, off blocks outputs.
// [RQ2] Phase starts above level, 30 to 130.
// [RQ3] Start drops below level minus hysteresis; the code also drops it at exactly that threshold.
// [RQ4] Start-only selector suppresses all trip outputs.
// [RQ5] Definite delay 0 to 60000 ms, default 100.
// [RQ6] Each phase has own comparator and timer.
// [RQ7] Phase trips after full delay, if allowed.
// [RQ8] Phase-to-phase mode relabels channels L12/L23/L31.
// [RQ9] Per-phase trips internal; only combined trip out.
// [RQ10] Blocking input holds start and trip inactive.
// [RQ11] Combined trip is OR of phase trips.
// [RQ12] Upstream supplies three RMS fundamental magnitudes.
// [RQ13] General start when any phase started.
// [RQ14] Level relative to nominal, common fixed-point scale.
// [RQ15] Timer clears on drop, block or off.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "dtov_defines.vh"

module dtov_trip #(
    parameter MAG_W = 16,
    parameter CYCLES_PER_MS = `DTOV_CYCLES_PER_MS
) (
    input wire aclk,
    input wire aresetn,
    input wire [MAG_W-1:0] phase_a_magnitude,
    input wire [MAG_W-1:0] phase_b_magnitude,
    input wire [MAG_W-1:0] phase_c_magnitude,
    input wire block_in,
    output reg phase_a_start,
    output reg phase_b_start,
    output reg phase_c_start,
    output reg any_phase_start,
    output reg combined_trip,
    output reg irq,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam CNT_W = 16;
    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;
    localparam integer MS_LAST_I = CYCLES_PER_MS - 1;
    localparam [CNT_W-1:0] MS_LAST = MS_LAST_I[CNT_W-1:0];
    localparam [MAG_W+7:0] PCT_DIV = {{(MAG_W+1){1'b0}}, 7'h64};

    // ------------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------------
    reg function_enable_sel;
    reg start_only_sel;
    reg p2p_mode;
    reg [7:0] start_level_pct;
    reg [3:0] dropoff_hysteresis_pct;
    reg [15:0] trip_delay_ms;
    reg [MAG_W-1:0] nominal_ref;
    reg [1:0] irq_stat;
    reg [1:0] irq_mask;

    // ------------------------------------------------------------------------
    // Thresholds in the magnitude scale
    // ------------------------------------------------------------------------
    // Both thresholds are nominal * pct / 100, so they share the input scale. [RQ14]
    // Products are kept wide so no percent setting can overflow them.
    wire [MAG_W+7:0] pick_prod = nominal_ref * start_level_pct;
    wire [MAG_W+7:0] drop_prod = nominal_ref * (start_level_pct - {4'h0, dropoff_hysteresis_pct});
    wire [MAG_W+7:0] pick_thr = pick_prod / PCT_DIV;
    wire [MAG_W+7:0] drop_thr = drop_prod / PCT_DIV;

    // Function is live only when switched on and not blocked. [RQ1] [RQ10]
    wire active = function_enable_sel & ~block_in;

    // Magnitudes gathered by channel index; in phase-to-phase mode the same
    // three channels stand for the L12, L23 and L31 pairs. [RQ8] [RQ12]
    wire [3*MAG_W-1:0] mags = {phase_c_magnitude, phase_b_magnitude, phase_a_magnitude};

    // ------------------------------------------------------------------------
    // Per-phase comparator and delay timer
    // ------------------------------------------------------------------------
    reg [2:0] started;
    reg [2:0] phase_trip;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : ph
            wire [MAG_W+7:0] mag = {8'h00, mags[g*MAG_W +: MAG_W]};
            reg [15:0] elapsed;
            reg [CNT_W-1:0] sub_ms;
            wire ms_done = (sub_ms == MS_LAST);

            // Each phase divides its own millisecond from the moment it starts,
            // so no tick that was already due can cut the delay short. [RQ5] [RQ6]
            always @(posedge aclk) begin
                if (!aresetn || !active || !started[g] || ms_done) begin
                    sub_ms <= {CNT_W{1'b0}};
                end else begin
                    sub_ms <= sub_ms + 1'b1;
                end
            end

            // Hysteresis comparator with its own state per channel. [RQ6]
            always @(posedge aclk) begin
                if (!aresetn || !active) begin
                    started[g] <= 1'b0;
                end else if (!started[g]) begin
                    started[g] <= (mag > pick_thr); // [RQ2]
                end else begin
                    // Landing exactly on the drop-off threshold is far enough below.
                    started[g] <= (mag > drop_thr); // [RQ3]
                end
            end

            // Timer runs while started, clears whenever the start is lost. [RQ15]
            always @(posedge aclk) begin
                if (!aresetn || !active || !started[g]) begin
                    elapsed <= 16'h0000;
                    phase_trip[g] <= 1'b0;
                end else begin
                    // Saturates so a start held for very long never wraps to zero.
                    if (ms_done && elapsed != 16'hFFFF) begin
                        elapsed <= elapsed + 16'h0001; // [RQ5]
                    end
                    // Kept internal; never drives a port directly. [RQ9]
                    phase_trip[g] <= (elapsed >= trip_delay_ms) & ~start_only_sel; // [RQ7]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Decision stage and outputs
    // ------------------------------------------------------------------------
    // All start and trip outputs are flops; gating by active keeps them low when off or blocked.
    wire next_any_start = |started;
    wire next_trip = active & ~start_only_sel & (|phase_trip);

    always @(posedge aclk) begin
        if (!aresetn) begin
            phase_a_start <= 1'b0;
            phase_b_start <= 1'b0;
            phase_c_start <= 1'b0;
            any_phase_start <= 1'b0;
            combined_trip <= 1'b0;
        end else begin
            phase_a_start <= started[0] & active;
            phase_b_start <= started[1] & active;
            phase_c_start <= started[2] & active;
            any_phase_start <= next_any_start & active; // [RQ13]
            combined_trip <= next_trip; // [RQ11] [RQ4] [RQ10]
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    // Address and data may come in either order; both are latched first.
    reg aw_held;
    reg w_held;
    reg [7:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;
    reg start_q;
    reg trip_q;
    wire start_evt = any_phase_start & ~start_q;
    wire trip_evt = combined_trip & ~trip_q;
    reg [1:0] clr;

    // Write-one-to-clear mask, live only in the cycle the write lands.
    always @* begin
        clr = 2'b00;
        if (wr_go && wr_addr == `DTOV_ADDR_IRQ_STAT && wr_strb[0]) begin
            clr = wr_data[1:0];
        end
    end

    // Each ready is a one-cycle pulse, so an item is never taken twice.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            function_enable_sel <= 1'b0;
            start_only_sel <= 1'b0;
            p2p_mode <= 1'b0;
            start_level_pct <= `DTOV_LEVEL_RESET;
            dropoff_hysteresis_pct <= `DTOV_HYST_RESET;
            trip_delay_ms <= `DTOV_DELAY_RESET;
            nominal_ref <= `DTOV_NOMINAL_RESET;
            irq_mask <= 2'b00;
            irq_stat <= 2'b00;
            start_q <= 1'b0;
            trip_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                case (wr_addr)
                    `DTOV_ADDR_CTRL: begin
                        if (wr_strb[0]) begin
                            function_enable_sel <= wr_data[`DTOV_CTRL_ENABLE_BIT]; // [RQ1]
                            start_only_sel <= wr_data[`DTOV_CTRL_START_ONLY_BIT]; // [RQ4]
                            p2p_mode <= wr_data[`DTOV_CTRL_P2P_BIT]; // [RQ8]
                        end
                    end
                    `DTOV_ADDR_LEVEL: begin
                        // Out-of-range settings are clamped into the legal span.
                        if (wr_strb[0]) begin
                            if (wr_data[7:0] < `DTOV_LEVEL_MIN) begin
                                start_level_pct <= `DTOV_LEVEL_MIN;
                            end else if (wr_data[7:0] > `DTOV_LEVEL_MAX) begin
                                start_level_pct <= `DTOV_LEVEL_MAX;
                            end else begin
                                start_level_pct <= wr_data[7:0]; // [RQ2]
                            end
                        end
                        if (wr_strb[1]) begin
                            if (wr_data[11:8] < `DTOV_HYST_MIN) begin
                                dropoff_hysteresis_pct <= `DTOV_HYST_MIN;
                            end else if (wr_data[11:8] > `DTOV_HYST_MAX) begin
                                dropoff_hysteresis_pct <= `DTOV_HYST_MAX;
                            end else begin
                                dropoff_hysteresis_pct <= wr_data[11:8]; // [RQ3]
                            end
                        end
                    end
                    `DTOV_ADDR_DELAY: begin
                        if (wr_strb[1:0] == 2'b11) begin
                            if (wr_data[15:0] > `DTOV_DELAY_MAX) begin
                                trip_delay_ms <= `DTOV_DELAY_MAX;
                            end else begin
                                trip_delay_ms <= wr_data[15:0]; // [RQ5]
                            end
                        end
                    end
                    `DTOV_ADDR_NOMINAL: begin
                        if (wr_strb[1:0] == 2'b11) begin
                            nominal_ref <= wr_data[MAG_W-1:0]; // [RQ14]
                        end
                    end
                    `DTOV_ADDR_IRQ_MASK: begin
                        if (wr_strb[0]) begin
                            irq_mask <= wr_data[1:0];
                        end
                    end
                    `DTOV_ADDR_IRQ_STAT: begin
                        // Cleared through clr by the sticky-bit logic below.
                    end
                    `DTOV_ADDR_STATUS: begin
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end
            // Rising edges of start and trip set sticky bits; set wins over clear.
            start_q <= any_phase_start;
            trip_q <= combined_trip;
            irq_stat[`DTOV_IRQ_START_BIT] <= start_evt |
                (irq_stat[`DTOV_IRQ_START_BIT] & ~clr[`DTOV_IRQ_START_BIT]);
            irq_stat[`DTOV_IRQ_TRIP_BIT] <= trip_evt |
                (irq_stat[`DTOV_IRQ_TRIP_BIT] & ~clr[`DTOV_IRQ_TRIP_BIT]);
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    // Data is taken in the handshake cycle and then held until rready.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    `DTOV_ADDR_CTRL: s_axi_rdata <= {29'h0, p2p_mode, start_only_sel,
                        function_enable_sel};
                    `DTOV_ADDR_LEVEL: s_axi_rdata <= {20'h0, dropoff_hysteresis_pct,
                        start_level_pct};
                    `DTOV_ADDR_DELAY: s_axi_rdata <= {16'h0, trip_delay_ms};
                    `DTOV_ADDR_NOMINAL: s_axi_rdata <= {{(32-MAG_W){1'b0}}, nominal_ref};
                    `DTOV_ADDR_STATUS: s_axi_rdata <= {24'h0, 1'b0, p2p_mode, combined_trip,
                        any_phase_start, 1'b0, started & {3{active}}};
                    `DTOV_ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
                    `DTOV_ADDR_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule

// ==== bench/dtov_trip_sva.sv ====
`timescale 1ns/10ps
module dtov_trip_sva (
    input wire aclk,
    input wire aresetn,
    input wire block_in,
    input wire phase_a_start,
    input wire phase_b_start,
    input wire phase_c_start,
    input wire any_phase_start,
    input wire combined_trip,
    input wire s_axi_awready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // One clock domain, so reset silences every check at once.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire st = phase_a_start | phase_b_start | phase_c_start;
    a_any_start: assert property (st && !block_in |-> ##[0:1] (any_phase_start || !st))
        else $error("general start missing while a phase is started");
    a_block_quiet: assert property (
        block_in [*3] |-> !st && !any_phase_start && !combined_trip)
        else $error("output active while blocked");
    a_trip_needs_start: assert property (
        combined_trip |-> any_phase_start || $past(any_phase_start))
        else $error("trip without start");
    a_trip_after_start: assert property ($rose(combined_trip) |-> $past(st))
        else $error("trip rose before any phase start");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    a_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data withdrawn or changed");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready longer than one cycle");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    c_trip: cover property ($rose(combined_trip));
    c_block: cover property (block_in && st);
    c_drop: cover property ($fell(any_phase_start));
endmodule

bind dtov_trip dtov_trip_sva dtov_trip_sva_inst (.aclk(aclk), .aresetn(aresetn),
    .block_in(block_in), .phase_a_start(phase_a_start), .phase_b_start(phase_b_start),
    .phase_c_start(phase_c_start), .any_phase_start(any_phase_start),
    .combined_trip(combined_trip), .s_axi_awready(s_axi_awready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ==== bench/dtov_mag_src.sv ====
`timescale 1ns/10ps
module dtov_mag_src (
    input wire aclk,
    output logic [15:0] phase_a_magnitude,
    output logic [15:0] phase_b_magnitude,
    output logic [15:0] phase_c_magnitude
);
    // Values hold between updates, as an upstream magnitude stage does.
    initial begin
        phase_a_magnitude = 16'h0000;
        phase_b_magnitude = 16'h0000;
        phase_c_magnitude = 16'h0000;
    end
    // Updates land just after an edge so the block never sees a half-changed set.
    task automatic set_mag(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge aclk);
        phase_a_magnitude <= a;
        phase_b_magnitude <= b;
        phase_c_magnitude <= c;
    endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`include "dtov_defines.vh"
module testbench;
    localparam int CPM = 4;
    localparam int NOM = int'(`DTOV_NOMINAL_RESET);
    localparam int PICK = NOM * int'(`DTOV_LEVEL_RESET) / 100;
    localparam int DROP = NOM * (int'(`DTOV_LEVEL_RESET) - int'(`DTOV_HYST_RESET)) / 100;
    localparam logic [15:0] OVER = 16'(PICK + 1000);
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic block_in = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0;
    wire [15:0] mag_a, mag_b, mag_c;
    wire st_a, st_b, st_c, any_phase_start, combined_trip, irq;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int bad_count = 0;
    int comparisons = 0;

    // ------------------------------------------------------------
    // Clock, partner and block
    // ------------------------------------------------------------
    // Period of 25 ns gives the 40 MHz system clock.
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    dtov_mag_src dtov_mag_src_inst (.aclk(aclk), .phase_a_magnitude(mag_a),
        .phase_b_magnitude(mag_b), .phase_c_magnitude(mag_c));
    dtov_trip #(.MAG_W(16), .CYCLES_PER_MS(CPM)) dtov_trip_inst (.aclk(aclk),
        .aresetn(aresetn), .phase_a_magnitude(mag_a), .phase_b_magnitude(mag_b),
        .phase_c_magnitude(mag_c), .block_in(block_in), .phase_a_start(st_a),
        .phase_b_start(st_b), .phase_c_start(st_c), .any_phase_start(any_phase_start),
        .combined_trip(combined_trip), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that runs out is counted and ends the run, so nothing hangs.
    task automatic hang;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        bad_count++;
        wrap_up();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit aw;
        bit w;
        n = 0;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (++n > 50) hang();
        end
        // Ready comes late on purpose, so the response must wait for it.
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (++n > 100) hang();
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (++n > 50) hang();
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (++n > 100) hang();
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
        if (er == 2'b00) chk(s_axi_rdata, exp);
    endtask
    // Waits for general start (sel 0) or general trip (sel 1) to reach v.
    task automatic wait_out(input int sel, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            if (++n > lim) hang();
        end while (((sel == 0) ? any_phase_start : combined_trip) !== v);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`DTOV_ADDR_CTRL, 32'h00000000, 2'b00);
        axr(`DTOV_ADDR_LEVEL, {20'h0, `DTOV_HYST_RESET, `DTOV_LEVEL_RESET}, 2'b00);
        axr(`DTOV_ADDR_DELAY, {16'h0, `DTOV_DELAY_RESET}, 2'b00);
        axr(`DTOV_ADDR_NOMINAL, {16'h0, `DTOV_NOMINAL_RESET}, 2'b00);
        axr(8'h1C, 32'h00000000, 2'b10);
        axw(8'h1C, 32'h00000001, 2'b10);
        axw(`DTOV_ADDR_DELAY, 32'h0000FFFF, 2'b00);
        axr(`DTOV_ADDR_DELAY, {16'h0, `DTOV_DELAY_MAX}, 2'b00);
        axw(`DTOV_ADDR_LEVEL, 32'h00000B05, 2'b00);
        axr(`DTOV_ADDR_LEVEL, {20'h0, `DTOV_HYST_MAX, `DTOV_LEVEL_MIN}, 2'b00);
        axw(`DTOV_ADDR_LEVEL, {20'h0, `DTOV_HYST_RESET, `DTOV_LEVEL_RESET}, 2'b00);
        axw(`DTOV_ADDR_DELAY, 32'h00000002, 2'b00);
        // Switched off, overvoltage on every phase must stay silent.
        dtov_mag_src_inst.set_mag(OVER, OVER, OVER);
        cyc(20);
        chk(32'({any_phase_start, combined_trip}), 32'h0);
        // Exactly at the level is not above it.
        dtov_mag_src_inst.set_mag(16'(PICK), 16'h0000, 16'h0000);
        axw(`DTOV_ADDR_CTRL, 32'h00000001, 2'b00);
        cyc(10);
        chk(32'(any_phase_start), 32'h0);
        dtov_mag_src_inst.set_mag(16'(PICK + 1), 16'h0000, 16'h0000);
        wait_out(0, 1'b1, 5);
        chk(32'({st_a, st_b, st_c}), 32'h4);
        cyc(5);
        chk(32'(combined_trip), 32'h0);
        wait_out(1, 1'b1, 20);
        // Events are latched but masked until the mask opens.
        chk(32'(irq), 32'h0);
        axr(`DTOV_ADDR_IRQ_STAT, 32'h00000003, 2'b00);
        axw(`DTOV_ADDR_IRQ_MASK, 32'h00000002, 2'b00);
        cyc(2);
        chk(32'(irq), 32'h1);
        axw(`DTOV_ADDR_IRQ_STAT, 32'h00000003, 2'b00);
        cyc(2);
        chk(32'(irq), 32'h0);
        // Inside the hysteresis band the start holds; a full band below it drops.
        dtov_mag_src_inst.set_mag(16'(DROP + 1), 16'h0000, 16'h0000);
        cyc(10);
        chk(32'(st_a), 32'h1);
        dtov_mag_src_inst.set_mag(16'(DROP), 16'h0000, 16'h0000);
        cyc(4);
        chk(32'({any_phase_start, combined_trip}), 32'h0);
        axw(`DTOV_ADDR_CTRL, 32'h00000003, 2'b00);
        dtov_mag_src_inst.set_mag(16'h0000, OVER, OVER);
        wait_out(0, 1'b1, 5);
        cyc(30);
        chk(32'({st_b, st_c, combined_trip}), 32'h6);
        axw(`DTOV_ADDR_CTRL, 32'h00000001, 2'b00);
        wait_out(1, 1'b1, 20);
        block_in <= 1'b1;
        cyc(4);
        chk(32'({st_b, st_c, any_phase_start, combined_trip}), 32'h0);
        block_in <= 1'b0;
        wait_out(0, 1'b1, 5);
        cyc(2);
        chk(32'(combined_trip), 32'h0);
        axw(`DTOV_ADDR_CTRL, 32'h00000007, 2'b00);
        axr(`DTOV_ADDR_STATUS, 32'h00000056, 2'b00);
        wrap_up();
    end
endmodule
